// >>> include/itc_pkg.sv
// constants and types for the interrupt, trap and reset block
package itc_pkg;
    localparam int           NUM_SRC        = 54;
    localparam int           SRC_W          = 6;
    localparam int           PRI_W          = 3;
    localparam int           NIB_W          = 4;
    localparam int           LVL_W          = 4;
    localparam int           VEC_W          = 8;
    localparam int           NUM_TRAP       = 8;
    localparam int           TRAP_W         = 3;
    localparam int           PAD_W          = 64;
    localparam int           SRC_PER_PRI    = 4;
    localparam int           SRC_PER_WORD   = 16;
    localparam int           ADDR_W         = 8;
    localparam int           DATA_W         = 32;
    localparam int           PC_W           = 24;
    localparam int           NUM_CAUSE      = 7;
    // register byte addresses
    localparam logic [7:0]   FLAG_BASE      = 8'h00;
    localparam logic [7:0]   ENABLE_BASE    = 8'h10;
    localparam logic [7:0]   PRI_BASE       = 8'h20;
    localparam logic [7:0]   PRI_LAST       = 8'h54;
    localparam logic [7:0]   STATUS_ADDR    = 8'h58;
    localparam logic [7:0]   CAUSE_ADDR     = 8'h5c;
    localparam logic [7:0]   WORD_STRIDE    = 8'h04;
    localparam logic [7:0]   FLAG_LAST      = 8'h0c;
    localparam logic [7:0]   ENABLE_LAST    = 8'h1c;
    // levels and vectors
    localparam logic [2:0]   LVL_DISABLED   = 3'h0;
    localparam logic [7:0]   IRQ_VEC_OFFSET = 8'h08;
    localparam logic [7:0]   TRAP_VEC_BASE  = 8'h00;
    localparam logic [2:0]   ADDR_ERR_TRAP  = 3'h4;
    localparam logic [2:0]   HARD_TRAP_MIN  = 3'h4;
    localparam logic [23:0]  RESET_PC       = 24'h000000;
    // reset cause bit positions
    localparam int           CAUSE_EXT      = 0;
    localparam int           CAUSE_WDT      = 1;
    localparam int           CAUSE_UNINIT   = 2;
    localparam int           CAUSE_ILLEGAL  = 3;
    localparam int           CAUSE_BROWNOUT = 4;
    localparam int           CAUSE_LOCKOUT  = 5;
    localparam int           CAUSE_SOFT     = 6;
    // core reset pulse length
    localparam int           CLK_PERIOD_NS  = 40;
    localparam int           RESET_HOLD_NS  = 200;
    localparam int           RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0]   RESET_HOLD_CNT = 4'(RESET_HOLD_CYC);

    typedef enum logic [2:0] {
        st_idle     = 3'b001,
        st_req_irq  = 3'b010,
        st_req_trap = 3'b100
    } req_state_t;
endpackage

// >>> hdl/natural_order_resolver.sv
// picks the winning pending source by level, then by interrupt number
module natural_order_resolver
    import itc_pkg::*;
(
    input  wire logic [NUM_SRC-1:0]       i_pending,
    input  wire logic [NUM_SRC*PRI_W-1:0] i_levels,
    output logic                          o_valid,
    output logic [SRC_W-1:0]              o_index,
    output logic [PRI_W-1:0]              o_level
);
    import itc_pkg::*;

    always_comb begin
        o_valid = 1'b0;
        o_index = '0;
        o_level = LVL_DISABLED;
        // scan from the highest number down so a tie leaves the lowest number
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (i_pending[i] && i_levels[i*PRI_W +: PRI_W] != LVL_DISABLED &&
                i_levels[i*PRI_W +: PRI_W] >= o_level) begin
                o_valid = 1'b1;
                o_index = SRC_W'(i);
                o_level = i_levels[i*PRI_W +: PRI_W];
            end
        end
    end
endmodule

// >>> hdl/reset_source_ctrl.sv
// gathers reset sources into a held core reset and sticky cause bits
module reset_source_ctrl
    import itc_pkg::*;
(
    input  wire logic                 i_core_clk,
    input  wire logic                 i_reset,
    input  wire logic [NUM_CAUSE-1:0] i_sources,
    input  wire logic [NUM_CAUSE-1:0] i_cause_clear,
    output logic                      o_core_reset,
    output logic [NUM_CAUSE-1:0]      o_cause
);
    import itc_pkg::*;

    logic [3:0] hold_cnt;

    // any source restarts the hold; core reset stays high while counting
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            hold_cnt     <= RESET_HOLD_CNT;
            o_core_reset <= 1'b1;
        end else if (|i_sources) begin
            hold_cnt     <= RESET_HOLD_CNT;
            o_core_reset <= 1'b1;
        end else if (hold_cnt != 4'h0) begin
            hold_cnt     <= hold_cnt - 4'h1;
            o_core_reset <= 1'b1;
        end else begin
            o_core_reset <= 1'b0;
        end
    end

    // new cause wins over a software clear in the same cycle
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            o_cause <= '0;
        end else begin
            o_cause <= (o_cause & ~i_cause_clear) | i_sources;
        end
    end
endmodule

// >>> hdl/interrupt_trap_priority_reset.sv
// interrupt priority, trap arbitration and reset entry with an apb register file
//
// Operation
// - three-bit level in low nibble bits
// - nibble top bit reads zero
// - level zero lowest, seven highest
// - equal level: smallest interrupt number wins
// - level decides first, number only ties
// - vector number is interrupt number plus eight
// - any reset forces program counter zero
// - first word jump then start address
// - six error conditions also reset
// - uninitialised pointer register use resets
// - executed illegal opcode resets, flushed not
// - simultaneous traps cause lockout reset
// - traps non-maskable with fixed priority
// - offending instruction completes before trap
// - traps levels eight to fifteen, msb set
// - level seven blocks interrupts, not traps
// - invalid trap vector raises address error
// - request only above current cpu level
// - level zero source never interrupts
module interrupt_trap_priority_reset
    import itc_pkg::*;
(
    input  wire logic                 i_core_clk,
    input  wire logic                 i_reset,
    input  wire logic                 i_psel,
    input  wire logic                 i_penable,
    input  wire logic                 i_pwrite,
    input  wire logic [ADDR_W-1:0]    i_paddr,
    input  wire logic [DATA_W-1:0]    i_pwdata,
    output logic [DATA_W-1:0]         o_prdata,
    output logic                      o_pready,
    output logic                      o_pslverr,
    input  wire logic [NUM_SRC-1:0]   i_irq_event,
    input  wire logic [PRI_W-1:0]     i_cpu_priority_level,
    input  wire logic                 i_irq_ack,
    input  wire logic [NUM_TRAP-1:0]  i_trap_event,
    input  wire logic                 i_trap_vector_invalid,
    input  wire logic                 i_instr_done,
    input  wire logic                 i_trap_return,
    input  wire logic                 i_ext_reset,
    input  wire logic                 i_wdt_timeout,
    input  wire logic                 i_uninit_wreg_ptr,
    input  wire logic                 i_illegal_opcode,
    input  wire logic                 i_opcode_flushed,
    input  wire logic                 i_brownout,
    input  wire logic                 i_sw_reset,
    output logic                      o_irq_req,
    output logic [VEC_W-1:0]          o_irq_vector,
    output logic [LVL_W-1:0]          o_irq_level,
    output logic                      o_cpu_priority_msb,
    output logic                      o_core_reset,
    output logic [PC_W-1:0]           o_reset_pc
);
    import itc_pkg::*;

    function automatic logic [2:0] top_trap(input logic [NUM_TRAP-1:0] v);
        top_trap = '0;
        for (int k = 0; k < NUM_TRAP; k++) begin
            if (v[k]) top_trap = TRAP_W'(k);
        end
    endfunction

    function automatic logic word_hit(input logic [7:0] a, input logic [7:0] lo,
                                      input logic [7:0] hi);
        word_hit = (a >= lo) && (a <= hi) && (a[1:0] == 2'b00);
    endfunction

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    logic                   bus_wr;
    logic                   bus_rd;
    logic [DATA_W-1:0]      next_rdata;
    logic                   next_err;
    logic [PAD_W-1:0]       flag_pad;
    logic [PAD_W-1:0]       enable_pad;
    logic [PAD_W*PRI_W-1:0] level_pad;
    logic [NUM_SRC-1:0]     flag;
    logic [NUM_SRC-1:0]     enable;
    logic [NUM_SRC*PRI_W-1:0] level;
    logic [NUM_CAUSE-1:0]   cause;
    logic [NUM_CAUSE-1:0]   cause_clear;
    logic [DATA_W-1:0]      status_word;
    logic [5:0]             word_idx;

    assign bus_wr   = i_psel && i_penable && o_pready && i_pwrite;
    assign bus_rd   = i_psel && i_penable && !o_pready && !i_pwrite;
    assign word_idx = i_paddr[7:2];
    assign flag_pad   = PAD_W'(flag);
    assign enable_pad = PAD_W'(enable);
    assign level_pad  = (PAD_W*PRI_W)'(level);

    always_comb begin
        next_rdata = '0;
        next_err   = 1'b0;
        if (word_hit(i_paddr, FLAG_BASE, FLAG_LAST)) begin
            next_rdata = DATA_W'(flag_pad[(word_idx - FLAG_BASE[7:2]) * SRC_PER_WORD +: 16]);
        end else if (word_hit(i_paddr, ENABLE_BASE, ENABLE_LAST)) begin
            next_rdata = DATA_W'(enable_pad[(word_idx - ENABLE_BASE[7:2]) * SRC_PER_WORD +: 16]);
        end else if (word_hit(i_paddr, PRI_BASE, PRI_LAST)) begin
            for (int n = 0; n < SRC_PER_PRI; n++) begin
                // top bit of each nibble left at zero
                next_rdata[n*NIB_W +: PRI_W] = level_pad[((word_idx - PRI_BASE[7:2]) *
                                               SRC_PER_PRI + n) * PRI_W +: PRI_W];
            end
        end else if (i_paddr == STATUS_ADDR) begin
            next_rdata = status_word;
        end else if (i_paddr == CAUSE_ADDR) begin
            next_rdata = DATA_W'(cause);
        end else begin
            next_err = 1'b1;
        end
    end

    // one wait state: ready rises in the second access cycle
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            o_pready  <= 1'b0;
            o_prdata  <= '0;
            o_pslverr <= 1'b0;
        end else begin
            o_pready  <= i_psel && i_penable && !o_pready;
            o_pslverr <= i_psel && i_penable && !o_pready && next_err;
            o_prdata  <= bus_rd ? next_rdata : '0;
        end
    end

    assign cause_clear = (bus_wr && i_paddr == CAUSE_ADDR) ? i_pwdata[NUM_CAUSE-1:0] : '0;

    // ------------------------------------------------------------
    // per-source flag, enable and level
    // ------------------------------------------------------------
    generate
        for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
            localparam logic [7:0] F_ADDR = FLAG_BASE + 8'((i / SRC_PER_WORD) * 4);
            localparam logic [7:0] E_ADDR = ENABLE_BASE + 8'((i / SRC_PER_WORD) * 4);
            localparam logic [7:0] P_ADDR = PRI_BASE + 8'((i / SRC_PER_PRI) * 4);
            localparam int         F_BIT  = i % SRC_PER_WORD;
            localparam int         P_BIT  = (i % SRC_PER_PRI) * NIB_W;

            // event wins over a software clear in the same cycle
            always_ff @(posedge i_core_clk or posedge i_reset) begin
                if (i_reset) begin
                    flag[i] <= 1'b0;
                end else if (o_core_reset) begin
                    flag[i] <= 1'b0;
                end else if (bus_wr && i_paddr == F_ADDR) begin
                    flag[i] <= i_pwdata[F_BIT] || i_irq_event[i];
                end else begin
                    flag[i] <= flag[i] || i_irq_event[i];
                end
            end

            always_ff @(posedge i_core_clk or posedge i_reset) begin
                if (i_reset) begin
                    enable[i] <= 1'b0;
                end else if (o_core_reset) begin
                    enable[i] <= 1'b0;
                end else if (bus_wr && i_paddr == E_ADDR) begin
                    enable[i] <= i_pwdata[F_BIT];
                end
            end

            always_ff @(posedge i_core_clk or posedge i_reset) begin
                if (i_reset) begin
                    level[i*PRI_W +: PRI_W] <= LVL_DISABLED;
                end else if (o_core_reset) begin
                    level[i*PRI_W +: PRI_W] <= LVL_DISABLED;
                end else if (bus_wr && i_paddr == P_ADDR) begin
                    level[i*PRI_W +: PRI_W] <= i_pwdata[P_BIT +: PRI_W];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // priority resolution
    // ------------------------------------------------------------
    logic             win_valid;
    logic [SRC_W-1:0] win_index;
    logic [PRI_W-1:0] win_level;

    natural_order_resolver u_resolver (
        .i_pending (flag & enable),
        .i_levels  (level),
        .o_valid   (win_valid),
        .o_index   (win_index),
        .o_level   (win_level)
    );

    // ------------------------------------------------------------
    // traps
    // ------------------------------------------------------------
    logic [NUM_TRAP-1:0] trap_raw;
    logic [NUM_TRAP-1:0] trap_pend;
    logic [NUM_TRAP-1:0] trap_ready;
    logic [NUM_TRAP-1:0] trap_take;
    logic                trap_active;
    logic [TRAP_W-1:0]   cur_trap;
    logic [TRAP_W-1:0]   best_trap;
    logic [LVL_W-1:0]    cpu_level;
    logic                multi_trap;
    logic                hard_conflict;
    logic                trap_ok;
    logic                irq_ok;
    req_state_t          state;

    assign trap_raw  = i_trap_event | (NUM_TRAP'(i_trap_vector_invalid) << ADDR_ERR_TRAP);
    assign multi_trap = (trap_raw & (trap_raw - 1'b1)) != '0;
    // only a lower hard trap conflicts; a lower soft trap just waits
    assign hard_conflict = trap_active && cur_trap >= HARD_TRAP_MIN &&
                           (trap_raw & ((NUM_TRAP'(1) << cur_trap) - 1'b1) &
                            ~((NUM_TRAP'(1) << HARD_TRAP_MIN) - 1'b1)) != '0;
    assign best_trap = top_trap(trap_ready);
    assign cpu_level = trap_active ? {1'b1, cur_trap} : {1'b0, i_cpu_priority_level};
    // traps ignore the enable and level registers entirely
    assign trap_ok   = trap_ready != '0 && {1'b1, best_trap} > cpu_level;
    assign irq_ok    = win_valid && {1'b0, win_level} > cpu_level;
    assign trap_take = (state == st_req_trap && i_irq_ack) ?
                       (NUM_TRAP'(1) << o_irq_vector[TRAP_W-1:0]) : '0;

    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            trap_pend <= '0;
        end else if (o_core_reset) begin
            trap_pend <= '0;
        end else begin
            trap_pend <= (trap_pend & ~trap_take) | trap_raw;
        end
    end

    // a trap becomes visible only once its instruction has completed
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            trap_ready <= '0;
        end else if (o_core_reset) begin
            trap_ready <= '0;
        end else begin
            trap_ready <= (trap_ready | (i_instr_done ? trap_pend : '0)) & ~trap_take;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            trap_active <= 1'b0;
            cur_trap    <= '0;
        end else if (o_core_reset) begin
            trap_active <= 1'b0;
            cur_trap    <= '0;
        end else if (trap_take != '0) begin
            trap_active <= 1'b1;
            cur_trap    <= o_irq_vector[TRAP_W-1:0];
        end else if (i_trap_return) begin
            trap_active <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            o_cpu_priority_msb <= 1'b0;
        end else begin
            o_cpu_priority_msb <= trap_active;
        end
    end

    // ------------------------------------------------------------
    // request to the core
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            state        <= st_idle;
            o_irq_req    <= 1'b0;
            o_irq_vector <= '0;
            o_irq_level  <= '0;
        end else if (o_core_reset) begin
            state        <= st_idle;
            o_irq_req    <= 1'b0;
        end else begin
            unique case (state)
                st_idle: begin
                    if (trap_ok) begin
                        state        <= st_req_trap;
                        o_irq_req    <= 1'b1;
                        o_irq_vector <= TRAP_VEC_BASE + VEC_W'(best_trap);
                        o_irq_level  <= {1'b1, best_trap};
                    end else if (irq_ok) begin
                        state        <= st_req_irq;
                        o_irq_req    <= 1'b1;
                        o_irq_vector <= IRQ_VEC_OFFSET + VEC_W'(win_index);
                        o_irq_level  <= {1'b0, win_level};
                    end
                end
                st_req_irq, st_req_trap: begin
                    if (i_irq_ack) begin
                        state     <= st_idle;
                        o_irq_req <= 1'b0;
                    end
                end
            endcase
        end
    end

    assign status_word = DATA_W'({trap_active, cur_trap, trap_pend, win_valid, win_index});

    // ------------------------------------------------------------
    // reset sources
    // ------------------------------------------------------------
    logic [NUM_CAUSE-1:0] reset_src;

    always_comb begin
        reset_src                 = '0;
        reset_src[CAUSE_EXT]      = i_ext_reset;
        reset_src[CAUSE_WDT]      = i_wdt_timeout;
        reset_src[CAUSE_UNINIT]   = i_uninit_wreg_ptr;
        reset_src[CAUSE_ILLEGAL]  = i_illegal_opcode && !i_opcode_flushed;
        reset_src[CAUSE_BROWNOUT] = i_brownout;
        reset_src[CAUSE_LOCKOUT]  = multi_trap || hard_conflict;
        reset_src[CAUSE_SOFT]     = i_sw_reset;
    end

    reset_source_ctrl u_reset_ctrl (
        .i_core_clk    (i_core_clk),
        .i_reset       (i_reset),
        .i_sources     (reset_src),
        .i_cause_clear (cause_clear),
        .o_core_reset  (o_core_reset),
        .o_cause       (cause)
    );

    // core fetches the boot jump from word zero once reset drops
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            o_reset_pc <= RESET_PC;
        end else begin
            o_reset_pc <= RESET_PC;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_no_level_zero: assert property (@(posedge i_core_clk) disable iff (i_reset)
        state == st_req_irq |-> o_irq_level != '0) else $error("level zero source requested");
    a_vector_offset: assert property (@(posedge i_core_clk) disable iff (i_reset)
        state == st_req_irq |-> o_irq_vector >= IRQ_VEC_OFFSET) else $error("bad irq vector");
    a_strictly_above: assert property (@(posedge i_core_clk) disable iff (i_reset)
        $rose(o_irq_req) |-> o_irq_level > $past(cpu_level)) else $error("request not above cpu");
    a_block_level_seven: assert property (@(posedge i_core_clk) disable iff (i_reset)
        (state == st_idle && !trap_active && i_cpu_priority_level == 3'h7)
        |=> state != st_req_irq) else $error("interrupt taken at level seven");
    a_msb_follows: assert property (@(posedge i_core_clk) disable iff (i_reset)
        $rose(trap_active) |=> o_cpu_priority_msb) else $error("msb not set in trap");
    a_lockout_reset: assert property (@(posedge i_core_clk) disable iff (i_reset)
        multi_trap |=> o_core_reset ##1 cause[CAUSE_LOCKOUT]) else $error("no lockout reset");
    a_flushed_safe: assert property (@(posedge i_core_clk) disable iff (i_reset)
        (i_illegal_opcode && i_opcode_flushed && !cause[CAUSE_ILLEGAL])
        |=> !cause[CAUSE_ILLEGAL]) else $error("flushed opcode caused reset");
    a_trap_level_range: assert property (@(posedge i_core_clk) disable iff (i_reset)
        state == st_req_trap |-> o_irq_level[LVL_W-1]) else $error("trap below level eight");
    a_nibble_msb_zero: assert property (@(posedge i_core_clk) disable iff (i_reset)
        (o_pready && !i_pwrite && word_hit(i_paddr, PRI_BASE, PRI_LAST))
        |-> (o_prdata & 32'h00008888) == '0) else $error("nibble top bit set");
endmodule

// >>> sim/core_model.sv
// core side: takes presented vectors, alternating prompt and slow acks
module core_model (
    input  wire logic i_core_clk,
    input  wire logic i_reset,
    input  wire logic i_irq_req,
    output logic      o_irq_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] cnt;
    logic       slow;
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            cnt       <= 3'h0;
            slow      <= 1'b0;
            o_irq_ack <= 1'b0;
        end else if (o_irq_ack) begin
            o_irq_ack <= 1'b0;
            cnt       <= 3'h0;
            slow      <= ~slow;
        end else if (i_irq_req) begin
            cnt <= cnt + 3'h1;
            o_irq_ack <= (cnt == (slow ? 3'h4 : 3'h0));
        end
    end
endmodule

// >>> sim/interrupt_trap_priority_reset_tb_top.sv
// self-checking bench for the interrupt, trap and reset block
module interrupt_trap_priority_reset_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import itc_pkg::*;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, ack, req, msb, crst, prdy, perr;
    logic tvi = 0, idone = 0, tret = 0, flush = 0;
    logic [7:0] addr = 0, tr = 0, vec;
    logic [31:0] wd = 0, prd, rv;
    logic [53:0] ev = 0;
    logic [2:0] cpu = 0;
    logic [5:0] rs = 0;
    logic [3:0] lvl;
    logic [23:0] pc;
    int miscompares = 0, comparisons = 0;
    int pos[6] = '{0, 1, 2, 3, 4, 6};
    interrupt_trap_priority_reset uut (.i_core_clk(clk), .i_reset(rst), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wd), .o_prdata(prd),
        .o_pready(prdy), .o_pslverr(perr), .i_irq_event(ev), .i_cpu_priority_level(cpu),
        .i_irq_ack(ack), .i_trap_event(tr), .i_trap_vector_invalid(tvi), .i_instr_done(idone),
        .i_trap_return(tret), .i_ext_reset(rs[0]), .i_wdt_timeout(rs[1]),
        .i_uninit_wreg_ptr(rs[2]), .i_illegal_opcode(rs[3]), .i_opcode_flushed(flush),
        .i_brownout(rs[4]), .i_sw_reset(rs[5]), .o_irq_req(req), .o_irq_vector(vec),
        .o_irq_level(lvl), .o_cpu_priority_msb(msb), .o_core_reset(crst), .o_reset_pc(pc));
    core_model core (.i_core_clk(clk), .i_reset(rst), .i_irq_req(req), .o_irq_ack(ack));
    initial begin
        forever #20 clk = ~clk;
    end
    task finish_test;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk) {psel, pen, pwr, addr, wd} <= {2'b10, w, a, d};
        @(posedge clk) pen <= 1;
        do begin
            @(posedge clk) n++;
        end while (prdy !== 1'b1 && n < 20);
        if (n >= 20) begin
            miscompares++;
            finish_test();
        end
        rv = prd;
        {psel, pen} <= 2'b00;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp);
        apb(0, a, 0);
        chk(rv, exp);
    endtask
    task waitcyc(input logic want, input logic [7:0] v, input logic [3:0] l);
        int n;
        for (n = 0; n < 12 && req !== 1'b1; n++) @(negedge clk);
        chk(req, want);
        if (want) chk({vec, lvl}, {v, l});
    endtask
    task waitrst;
        int n;
        for (n = 0; n < 30 && crst !== 1'b0; n++) @(negedge clk);
        chk(crst, 0);
    endtask
    task pulse_ev(input logic [53:0] e);
        @(posedge clk) ev <= e;
        @(posedge clk) ev <= '0;
    endtask
    task t_regs;
        apb(1, PRI_BASE + 8'h0c, 32'hffff_ffff);
        rd(PRI_BASE + 8'h0c, 32'h7777);
        rd(8'h80, 0);
        chk(perr, 1);
        chk(pc, RESET_PC);
    endtask
    task t_irq;
        apb(1, ENABLE_BASE, 32'h2b);
        apb(1, ENABLE_BASE + 8'h08, 32'h400);
        apb(1, PRI_BASE, 32'h2001);
        apb(1, PRI_BASE + 8'h04, 32'h20);
        apb(1, PRI_BASE + 8'h28, 32'h700);
        pulse_ev(54'h1 | (54'h1 << 42));
        waitcyc(1, 8'd50, 4'h7);
        apb(1, FLAG_BASE + 8'h08, 0);
        repeat (8) @(posedge clk);
        waitcyc(1, 8'd8, 4'h1);
        apb(1, FLAG_BASE, 0);
        repeat (8) @(posedge clk);
        pulse_ev(54'h28);
        waitcyc(1, 8'd11, 4'h2);
        apb(1, FLAG_BASE, 0);
        repeat (8) @(posedge clk);
        pulse_ev(54'h2);
        waitcyc(0, 0, 0);
    endtask
    task t_trap;
        @(posedge clk) cpu <= 3'h7;
        pulse_ev(54'h1 << 42);
        waitcyc(0, 0, 0);
        @(posedge clk) tr <= 8'h04;
        @(posedge clk) tr <= 8'h00;
        waitcyc(0, 0, 0);
        @(posedge clk) idone <= 1;
        @(posedge clk) idone <= 0;
        waitcyc(1, 8'd2, 4'ha);
        repeat (10) @(negedge clk);
        chk(msb, 1);
        @(posedge clk) {tret, tvi, idone} <= 3'b100;
        @(posedge clk) {tret, tvi, idone} <= 3'b010;
        @(posedge clk) {tret, tvi, idone} <= 3'b001;
        @(posedge clk) idone <= 0;
        waitcyc(1, 8'd4, 4'hc);
        repeat (10) @(posedge clk);
        tret <= 1;
        @(posedge clk) tret <= 0;
        repeat (3) @(negedge clk);
        chk(msb, 0);
    endtask
    task t_resets;
        int i;
        @(posedge clk) {rs, flush} <= {6'h08, 1'b1};
        @(posedge clk) {rs, flush} <= 7'h0;
        repeat (2) @(negedge clk);
        chk(crst, 0);
        for (i = 0; i < 7; i++) begin
            @(posedge clk);
            if (i < 6) rs <= 6'h1 << i;
            else tr <= 8'h03;
            @(posedge clk) {rs, tr} <= '0;
            repeat (2) @(negedge clk);
            chk({crst, pc}, {1'b1, RESET_PC});
            waitrst();
            rd(CAUSE_ADDR, 32'h1 << (i < 6 ? pos[i] : CAUSE_LOCKOUT));
            apb(1, CAUSE_ADDR, 32'h7f);
        end
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst <= 0;
        waitrst();
        t_regs();
        t_irq();
        t_trap();
        t_resets();
        finish_test();
    end
    initial begin
        #2000000;
        miscompares++;
        finish_test();
    end
endmodule
